// ===== rtl/mmc_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH

`define MMC_ADDR_SINGLE 7'h00
`define MMC_ADDR_CONT 7'h01
`define MMC_ADDR_CCX_HI 7'h04
`define MMC_ADDR_CCX_LO 7'h05
`define MMC_ADDR_CCY_HI 7'h06
`define MMC_ADDR_CCY_LO 7'h07
`define MMC_ADDR_CCZ_HI 7'h08
`define MMC_ADDR_CCZ_LO 7'h09
`define MMC_ADDR_RATE 7'h0B
`define MMC_ADDR_X_RES 7'h24
`define MMC_ADDR_Y_RES 7'h27
`define MMC_ADDR_Z_RES 7'h2A
`define MMC_ADDR_SELF_TEST 7'h33
`define MMC_ADDR_STATUS 7'h34
`define MMC_ADDR_HANDSHAKE 7'h35
`define MMC_ADDR_REVISION 7'h36

`define MMC_CMD_READ_BIT 7
`define MMC_CONT_START_BIT 0
`define MMC_CONT_MODE_BIT 2
`define MMC_AXIS_LSB 4
`define MMC_AXIS_MSB 6
`define MMC_STATUS_READY_BIT 7

`define MMC_SINGLE_RESET 8'h00
`define MMC_CONT_RESET 8'h00
`define MMC_CC_RESET 16'h00C8
`define MMC_RATE_RESET 8'h96
`define MMC_RATE_FIXED_HI 4'h9
`define MMC_SELF_TEST_RESET 8'h00
`define MMC_HANDSHAKE_RESET 8'h1B
`define MMC_RESULT_RESET 24'h000000

`define MMC_CLK_PERIOD_PS 4000
`define MMC_RATE_UNIT_NS 420000

`endif

// ===== rtl/mmc_pkg.sv
// types shared by the measurement control block
package mmc_pkg;
   typedef logic [7:0] mmc_byte_t;
   typedef logic [6:0] mmc_addr_t;
   typedef logic [2:0] mmc_axes_t;
   typedef logic [23:0] mmc_result_t;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_NEXT = 3'b010,
      SEQ_MEAS = 3'b100
   } mmc_seq_state_t;
endpackage

// ===== rtl/mmc_axis_counter.sv
// one-axis forward and reverse bias oscillation period counter
`timescale 1ns/1ps
`include "mmc_regs.svh"
module mmc_axis_counter (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic [15:0] cycles_i,
   input wire logic osc_tick_i,
   output logic busy_o,
   output logic reverse_o,
   output logic done_o,
   output mmc_pkg::mmc_result_t result_o
);
   import mmc_pkg::*;

   logic [15:0] osc_cnt_reg;
   mmc_result_t timer_reg;
   mmc_result_t fwd_time_reg;
   logic phase_end;

   assign phase_end = busy_o && (osc_cnt_reg == cycles_i);

   // count sensor cycles, first forward then reverse bias
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
         reverse_o <= 1'b0;
         osc_cnt_reg <= 16'h0000;
         timer_reg <= 24'h000000;
         fwd_time_reg <= 24'h000000;
      end else if (start_i && !busy_o) begin
         busy_o <= 1'b1;
         reverse_o <= 1'b0;
         osc_cnt_reg <= 16'h0000;
         timer_reg <= 24'h000000;
      end else if (phase_end) begin
         osc_cnt_reg <= 16'h0000;
         timer_reg <= 24'h000000;
         if (!reverse_o) begin
            reverse_o <= 1'b1;
            fwd_time_reg <= timer_reg;
         end else begin
            reverse_o <= 1'b0;
            busy_o <= 1'b0;
         end
      end else if (busy_o) begin
         timer_reg <= timer_reg + 24'h000001;
         if (osc_tick_i) begin
            osc_cnt_reg <= osc_cnt_reg + 16'h0001;
         end
      end
   end

   // difference of the two phase durations is the field reading
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_o <= 1'b0;
         result_o <= `MMC_RESULT_RESET;
      end else begin
         done_o <= phase_end && reverse_o;
         if (phase_end && reverse_o) begin
            result_o <= fwd_time_reg - timer_reg;
         end
      end
   end
endmodule

// ===== rtl/mmc_measure_control.sv
// register bank and measurement sequencer of the three-axis sensor controller
`timescale 1ns/1ps
`include "mmc_regs.svh"

// Operation
// - command byte low seven bits address; bit 7 zero means write, data follows
// - bit 7 one means read; device returns the addressed register contents
// - device leaves reset idle and idles when no transfer or measurement runs
// - per-axis 16-bit cycle count, high byte at lower address, 04/06/08
// - cycle counts reset to 200 decimal: low byte C8, high byte zero
// - register address advances by one after every data byte of a transfer
// - each axis counts its own cycle count in forward and reverse bias
// - cycle counts keep their value until rewritten or reset
// - bit 0 of continuous control at 01 starts or stops continuous mode
// - single trigger write is ignored while continuous mode runs
// - continuous mode measures only axes enabled by bits 4, 5 and 6
// - ready mode 0: ready after whole sequence; 1: after each axis
// - reading continuous control returns the byte layout as written
// - reading continuous control or writing rate register ends continuous mode
// - read-only 24-bit results at 24, 27, 2A, reset to zero
// - single trigger at 00, bits 6..4 pick axes; ready after all finish
// - status bit 7 shows new data ready
// - rate low nibble sets interval; upper nibble fixed 9, default 96
module mmc_measure_control #(
   parameter int unsigned RATE_UNIT_CYCLES =
      (`MMC_RATE_UNIT_NS * 1000) / `MMC_CLK_PERIOD_PS,
   parameter logic [7:0] REVISION_VALUE = 8'h5A
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic frame_i,
   input wire logic byte_valid_i,
   input mmc_pkg::mmc_byte_t byte_i,
   input mmc_pkg::mmc_axes_t osc_tick_i,
   output mmc_pkg::mmc_byte_t tx_byte_o,
   output logic new_data_ready_o,
   output mmc_pkg::mmc_axes_t sensor_sel_o,
   output logic bias_reverse_o,
   output logic meas_active_o,
   output logic idle_o
);
   import mmc_pkg::*;

   function automatic mmc_axes_t lowest_one(input mmc_axes_t v);
      mmc_axes_t r;
      r = 3'h0;
      if (v[0]) begin
         r = 3'h1;
      end else if (v[1]) begin
         r = 3'h2;
      end else if (v[2]) begin
         r = 3'h4;
      end
      return r;
   endfunction

   // host command state
   logic cmd_seen_reg;
   logic read_mode_reg;
   mmc_addr_t addr_reg;

   // register bank
   mmc_byte_t single_measure_trigger_reg;
   mmc_byte_t continuous_mode_control_reg;
   logic [15:0] x_cycle_count_reg;
   logic [15:0] y_cycle_count_reg;
   logic [15:0] z_cycle_count_reg;
   logic [3:0] rate_nibble_reg;
   mmc_result_t x_result_reg;
   mmc_result_t y_result_reg;
   mmc_result_t z_result_reg;
   mmc_byte_t self_test_control_reg;
   mmc_byte_t command_handshake_reg;
   logic new_data_ready_reg;

   // sequencer
   mmc_seq_state_t seq_state_reg;
   mmc_axes_t pending_reg;
   mmc_axes_t cur_axis_reg;
   logic each_axis_ready_reg;
   logic axis_start_reg;
   logic [31:0] interval_cnt_reg;

   logic wr_en;
   logic rd_take;
   logic single_go;
   logic cont_go;
   logic cont_running;
   logic [15:0] cur_cycles;
   logic cur_osc_tick;
   logic axis_busy;
   logic axis_reverse;
   logic axis_done;
   mmc_result_t axis_result;
   mmc_byte_t rd_byte;
   logic [31:0] interval_cycles;

   assign wr_en = frame_i && byte_valid_i && cmd_seen_reg && !read_mode_reg;
   assign rd_take = frame_i && byte_valid_i && cmd_seen_reg && read_mode_reg;
   assign cont_running = continuous_mode_control_reg[`MMC_CONT_START_BIT];
   assign interval_cycles = RATE_UNIT_CYCLES << rate_nibble_reg;

   // single trigger only accepted outside continuous mode
   assign single_go = wr_en && (addr_reg == `MMC_ADDR_SINGLE) && !cont_running;
   assign cont_go = cont_running && (interval_cnt_reg == 32'h0000_0000) &&
      (seq_state_reg == SEQ_IDLE);

   // command byte then data bytes with address auto-increment
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cmd_seen_reg <= 1'b0;
         read_mode_reg <= 1'b0;
         addr_reg <= 7'h00;
      end else if (!frame_i) begin
         cmd_seen_reg <= 1'b0;
      end else if (byte_valid_i) begin
         if (!cmd_seen_reg) begin
            cmd_seen_reg <= 1'b1;
            read_mode_reg <= byte_i[`MMC_CMD_READ_BIT];
            addr_reg <= byte_i[6:0];
         end else begin
            addr_reg <= addr_reg + 7'h01;
         end
      end
   end

   // read multiplexer
   always_comb begin
      rd_byte = 8'h00;
      unique case (addr_reg)
         `MMC_ADDR_SINGLE: rd_byte = single_measure_trigger_reg;
         `MMC_ADDR_CONT: rd_byte = continuous_mode_control_reg;
         `MMC_ADDR_CCX_HI: rd_byte = x_cycle_count_reg[15:8];
         `MMC_ADDR_CCX_LO: rd_byte = x_cycle_count_reg[7:0];
         `MMC_ADDR_CCY_HI: rd_byte = y_cycle_count_reg[15:8];
         `MMC_ADDR_CCY_LO: rd_byte = y_cycle_count_reg[7:0];
         `MMC_ADDR_CCZ_HI: rd_byte = z_cycle_count_reg[15:8];
         `MMC_ADDR_CCZ_LO: rd_byte = z_cycle_count_reg[7:0];
         `MMC_ADDR_RATE: rd_byte = {`MMC_RATE_FIXED_HI, rate_nibble_reg};
         7'h24: rd_byte = x_result_reg[23:16];
         7'h25: rd_byte = x_result_reg[15:8];
         7'h26: rd_byte = x_result_reg[7:0];
         7'h27: rd_byte = y_result_reg[23:16];
         7'h28: rd_byte = y_result_reg[15:8];
         7'h29: rd_byte = y_result_reg[7:0];
         7'h2A: rd_byte = z_result_reg[23:16];
         7'h2B: rd_byte = z_result_reg[15:8];
         7'h2C: rd_byte = z_result_reg[7:0];
         `MMC_ADDR_SELF_TEST: rd_byte = {self_test_control_reg[7], 3'h0,
            self_test_control_reg[3:0]};
         `MMC_ADDR_STATUS: rd_byte = {new_data_ready_reg, 7'h00};
         `MMC_ADDR_HANDSHAKE: rd_byte = command_handshake_reg;
         `MMC_ADDR_REVISION: rd_byte = REVISION_VALUE;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tx_byte_o <= 8'h00;
      end else begin
         tx_byte_o <= rd_byte;
      end
   end

   // single trigger register keeps the last accepted axis selection
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         single_measure_trigger_reg <= `MMC_SINGLE_RESET;
      end else if (single_go) begin
         single_measure_trigger_reg <= byte_i;
      end
   end

   // continuous control: written byte, start bit dropped by side effects
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         continuous_mode_control_reg <= `MMC_CONT_RESET;
      end else if (wr_en && addr_reg == `MMC_ADDR_CONT) begin
         continuous_mode_control_reg <= byte_i;
      end else if ((rd_take && addr_reg == `MMC_ADDR_CONT) ||
                   (wr_en && addr_reg == `MMC_ADDR_RATE)) begin
         continuous_mode_control_reg[`MMC_CONT_START_BIT] <= 1'b0;
      end
   end

   // cycle counts, high byte at the lower address
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         x_cycle_count_reg <= `MMC_CC_RESET;
         y_cycle_count_reg <= `MMC_CC_RESET;
         z_cycle_count_reg <= `MMC_CC_RESET;
      end else if (wr_en) begin
         unique case (addr_reg)
            `MMC_ADDR_CCX_HI: x_cycle_count_reg[15:8] <= byte_i;
            `MMC_ADDR_CCX_LO: x_cycle_count_reg[7:0] <= byte_i;
            `MMC_ADDR_CCY_HI: y_cycle_count_reg[15:8] <= byte_i;
            `MMC_ADDR_CCY_LO: y_cycle_count_reg[7:0] <= byte_i;
            `MMC_ADDR_CCZ_HI: z_cycle_count_reg[15:8] <= byte_i;
            `MMC_ADDR_CCZ_LO: z_cycle_count_reg[7:0] <= byte_i;
            default: ;
         endcase
      end
   end

   // rate, self test and handshake registers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rate_nibble_reg <= 4'(`MMC_RATE_RESET & 8'h0F);
         self_test_control_reg <= `MMC_SELF_TEST_RESET;
         command_handshake_reg <= `MMC_HANDSHAKE_RESET;
      end else if (wr_en) begin
         if (addr_reg == `MMC_ADDR_RATE) begin
            rate_nibble_reg <= byte_i[3:0];
         end
         if (addr_reg == `MMC_ADDR_SELF_TEST) begin
            self_test_control_reg <= byte_i;
         end
         if (addr_reg == `MMC_ADDR_HANDSHAKE) begin
            command_handshake_reg <= byte_i;
         end
      end
   end

   // interval between continuous sequences
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         interval_cnt_reg <= 32'h0000_0000;
      end else if (!cont_running) begin
         interval_cnt_reg <= 32'h0000_0000;
      end else if (cont_go) begin
         interval_cnt_reg <= interval_cycles - 32'h0000_0001;
      end else if (interval_cnt_reg != 32'h0000_0000) begin
         interval_cnt_reg <= interval_cnt_reg - 32'h0000_0001;
      end
   end

   // axis sequencer
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         seq_state_reg <= SEQ_IDLE;
         pending_reg <= 3'h0;
         cur_axis_reg <= 3'h0;
         each_axis_ready_reg <= 1'b0;
         axis_start_reg <= 1'b0;
      end else begin
         axis_start_reg <= 1'b0;
         unique case (seq_state_reg)
            SEQ_IDLE: begin
               if (single_go) begin
                  pending_reg <= byte_i[`MMC_AXIS_MSB:`MMC_AXIS_LSB];
                  each_axis_ready_reg <= 1'b0;
                  seq_state_reg <= SEQ_NEXT;
               end else if (cont_go) begin
                  pending_reg <= continuous_mode_control_reg[`MMC_AXIS_MSB:`MMC_AXIS_LSB];
                  each_axis_ready_reg <= continuous_mode_control_reg[`MMC_CONT_MODE_BIT];
                  seq_state_reg <= SEQ_NEXT;
               end
            end
            SEQ_NEXT: begin
               if (pending_reg == 3'h0) begin
                  seq_state_reg <= SEQ_IDLE;
               end else begin
                  cur_axis_reg <= lowest_one(pending_reg);
                  axis_start_reg <= 1'b1;
                  seq_state_reg <= SEQ_MEAS;
               end
            end
            SEQ_MEAS: begin
               if (axis_done) begin
                  pending_reg <= pending_reg & ~cur_axis_reg;
                  seq_state_reg <= SEQ_NEXT;
               end
            end
         endcase
      end
   end

   // results land in the register of the axis just measured
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         x_result_reg <= `MMC_RESULT_RESET;
         y_result_reg <= `MMC_RESULT_RESET;
         z_result_reg <= `MMC_RESULT_RESET;
      end else if (axis_done) begin
         if (cur_axis_reg[0]) begin
            x_result_reg <= axis_result;
         end
         if (cur_axis_reg[1]) begin
            y_result_reg <= axis_result;
         end
         if (cur_axis_reg[2]) begin
            z_result_reg <= axis_result;
         end
      end
   end

   // ready flag: cleared at sequence start, set per axis or at sequence end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         new_data_ready_reg <= 1'b0;
      end else if (seq_state_reg == SEQ_IDLE && (single_go || cont_go)) begin
         new_data_ready_reg <= 1'b0;
      end else if (axis_done && each_axis_ready_reg) begin
         new_data_ready_reg <= 1'b1;
      end else if (seq_state_reg == SEQ_NEXT && pending_reg == 3'h0) begin
         new_data_ready_reg <= 1'b1;
      end
   end

   // a tick counts only once the bias pin shows the counter's own phase
   always_comb begin
      cur_cycles = 16'h0000;
      cur_osc_tick = 1'b0;
      unique case (cur_axis_reg)
         3'h1: begin
            cur_cycles = x_cycle_count_reg;
            cur_osc_tick = osc_tick_i[0] && (bias_reverse_o == axis_reverse);
         end
         3'h2: begin
            cur_cycles = y_cycle_count_reg;
            cur_osc_tick = osc_tick_i[1] && (bias_reverse_o == axis_reverse);
         end
         3'h4: begin
            cur_cycles = z_cycle_count_reg;
            cur_osc_tick = osc_tick_i[2] && (bias_reverse_o == axis_reverse);
         end
         default: begin
            cur_cycles = 16'h0000;
            cur_osc_tick = 1'b0;
         end
      endcase
   end

   mmc_axis_counter u_axis (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .start_i(axis_start_reg),
      .cycles_i(cur_cycles),
      .osc_tick_i(cur_osc_tick),
      .busy_o(axis_busy),
      .reverse_o(axis_reverse),
      .done_o(axis_done),
      .result_o(axis_result)
   );

   // registered pin outputs
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         new_data_ready_o <= 1'b0;
         sensor_sel_o <= 3'h0;
         bias_reverse_o <= 1'b0;
         meas_active_o <= 1'b0;
         idle_o <= 1'b1;
      end else begin
         new_data_ready_o <= new_data_ready_reg;
         sensor_sel_o <= axis_busy ? cur_axis_reg : 3'h0;
         bias_reverse_o <= axis_busy && axis_reverse;
         meas_active_o <= seq_state_reg != SEQ_IDLE;
         idle_o <= !frame_i && seq_state_reg == SEQ_IDLE;
      end
   end
endmodule

// ===== verification/mmc_sensor_model.sv
// oscillator front end model: ticks the selected axis at a set period per bias phase
`timescale 1ns/1ps
module mmc_sensor_model (
   input wire logic clk_i,
   input mmc_pkg::mmc_axes_t sel_i,
   input wire logic rev_i,
   input wire logic [3:0] fwd_per_i,
   input wire logic [3:0] rev_per_i,
   output mmc_pkg::mmc_axes_t tick_o
);
   import mmc_pkg::*;
   mmc_axes_t sel_reg = 3'h0;
   logic rev_reg = 1'b0;
   logic [3:0] cnt_reg = 4'h0;
   logic [3:0] per;
   logic hit;
   assign per = rev_reg ? rev_per_i : fwd_per_i;
   assign hit = sel_i == sel_reg && rev_i == rev_reg && cnt_reg == per - 4'h1;
   always_ff @(posedge clk_i) begin
      sel_reg <= sel_i;
      rev_reg <= rev_i;
      // period restarts whenever axis or bias phase changes
      if (sel_i != sel_reg || rev_i != rev_reg || hit)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= cnt_reg + 4'h1;
   end
   assign tick_o = hit ? sel_i : 3'h0;
endmodule

// ===== verification/mmc_measure_control_sva.sv
// port checker for the measurement control block
`timescale 1ns/1ps
module mmc_measure_control_sva (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic frame_i,
   input wire logic byte_valid_i,
   input mmc_pkg::mmc_byte_t byte_i,
   input mmc_pkg::mmc_axes_t osc_tick_i,
   input mmc_pkg::mmc_byte_t tx_byte_o,
   input wire logic new_data_ready_o,
   input mmc_pkg::mmc_axes_t sensor_sel_o,
   input wire logic bias_reverse_o,
   input wire logic meas_active_o,
   input wire logic idle_o
);
   import mmc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence seq_start;
      $rose(meas_active_o);
   endsequence
   sequence seq_rev_end;
      $fell(bias_reverse_o);
   endsequence
   chk_reset_quiet:
      assert property (disable iff (1'b0) !nrst_i |=> idle_o && !meas_active_o)
      else $error("busy right after reset");
   chk_frame_wake:
      assert property (frame_i |=> !idle_o)
      else $error("idle during host transfer");
   chk_quiet_idle:
      assert property ((!frame_i && !meas_active_o) [*3] |-> idle_o)
      else $error("not idle while quiet");
   chk_sel_onehot:
      assert property ($onehot0(sensor_sel_o))
      else $error("more than one axis selected");
   chk_sel_active:
      assert property (sensor_sel_o != 3'h0 |-> meas_active_o)
      else $error("axis selected while sequencer idle");
   chk_rev_axis:
      assert property (bias_reverse_o |-> sensor_sel_o != 3'h0)
      else $error("reverse bias with no axis");
   chk_rev_same:
      assert property ($rose(bias_reverse_o) |-> $stable(sensor_sel_o))
      else $error("axis changed at bias reversal");
   chk_axis_done:
      assert property (seq_rev_end |-> sensor_sel_o != $past(sensor_sel_o))
      else $error("axis kept after reverse phase");
   chk_ready_clear:
      assert property (seq_start |-> ##[0:1] !new_data_ready_o)
      else $error("ready kept at sequence start");
endmodule
bind mmc_measure_control mmc_measure_control_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i),
   .frame_i(frame_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
   .osc_tick_i(osc_tick_i), .tx_byte_o(tx_byte_o), .new_data_ready_o(new_data_ready_o),
   .sensor_sel_o(sensor_sel_o), .bias_reverse_o(bias_reverse_o),
   .meas_active_o(meas_active_o), .idle_o(idle_o));

// ===== verification/mmc_measure_control_tb.sv
// self-checking bench for the measurement control block
`timescale 1ns/1ps
module mmc_measure_control_tb;
   import mmc_pkg::*;
   localparam int unsigned UNIT = 8;
   localparam logic [14:0] RST_TAB [13] = '{15'h0000, 15'h0100, 15'h0400, 15'h05C8,
      15'h0600, 15'h07C8, 15'h0800, 15'h09C8, 15'h0B96, 15'h3300, 15'h3400, 15'h351B,
      15'h363C};
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic frame_i = 1'b0;
   logic byte_valid_i = 1'b0;
   mmc_byte_t byte_i = 8'h00;
   mmc_axes_t osc_tick_i, sensor_sel_o, seen_sel, en;
   mmc_byte_t tx_byte_o, mask;
   logic new_data_ready_o, bias_reverse_o, meas_active_o, idle_o, seen_late;
   logic [3:0] fwd_per = 4'h3;
   logic [3:0] rev_per = 4'h2;
   logic [31:0] seed = 32'h09E0;
   logic [23:0] res_exp [3] = '{24'h000000, 24'h000000, 24'h000000};
   logic [15:0] cc [3];
   logic [23:0] v;
   int n_fail = 0;
   int comparisons = 0;
   int nx;
   always #2 clk_i = ~clk_i;
   // revision value is arbitrary
   mmc_measure_control #(.RATE_UNIT_CYCLES(UNIT), .REVISION_VALUE(8'h3C)) u_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .frame_i(frame_i), .byte_valid_i(byte_valid_i),
      .byte_i(byte_i), .osc_tick_i(osc_tick_i), .tx_byte_o(tx_byte_o),
      .new_data_ready_o(new_data_ready_o), .sensor_sel_o(sensor_sel_o),
      .bias_reverse_o(bias_reverse_o), .meas_active_o(meas_active_o), .idle_o(idle_o));
   mmc_sensor_model u_sensor (.clk_i(clk_i), .sel_i(sensor_sel_o), .rev_i(bias_reverse_o),
      .fwd_per_i(fwd_per), .rev_per_i(rev_per), .tick_o(osc_tick_i));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [23:0] exp_res(input logic [15:0] c, input logic [3:0] f,
      input logic [3:0] r);
      return {8'h00, c} * {20'h00000, f} - {8'h00, c} * {20'h00000, r};
   endfunction
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input mmc_byte_t b);
      @(negedge clk_i);
      byte_valid_i = 1'b1;
      byte_i = b;
      @(negedge clk_i);
      byte_valid_i = 1'b0;
   endtask
   task automatic wr8(input mmc_addr_t a, input mmc_byte_t d);
      @(negedge clk_i);
      frame_i = 1'b1;
      put({1'b0, a});
      put(d);
      frame_i = 1'b0;
   endtask
   task automatic wr16(input mmc_addr_t a, input logic [15:0] d);
      @(negedge clk_i);
      frame_i = 1'b1;
      put({1'b0, a});
      put(d[15:8]);
      put(d[7:0]);
      frame_i = 1'b0;
   endtask
   // each data byte is sampled before the next pulse consumes it
   task automatic rd(input mmc_addr_t a, input int n, output logic [23:0] val);
      val = 24'h000000;
      @(negedge clk_i);
      frame_i = 1'b1;
      put({1'b1, a});
      for (int i = 0; i < n; i++) begin
         repeat (2) @(negedge clk_i);
         val = {val[15:0], tx_byte_o};
         put(8'hFF);
      end
      frame_i = 1'b0;
   endtask
   task automatic wait_on(input logic act, input logic lv);
      int k;
      k = 0;
      while ((act ? meas_active_o : new_data_ready_o) !== lv) begin
         @(negedge clk_i);
         k++;
         if (k > 4000) begin
            n_fail++;
            complete_run();
         end
      end
   endtask
   task automatic watch(input int cycles);
      logic px;
      px = sensor_sel_o[0];
      seen_sel = 3'h0;
      seen_late = 1'b0;
      nx = 0;
      for (int i = 0; i < cycles; i++) begin
         @(negedge clk_i);
         seen_sel = seen_sel | sensor_sel_o;
         if (new_data_ready_o && sensor_sel_o[2:1] != 2'h0)
            seen_late = 1'b1;
         if (sensor_sel_o[0] && !px)
            nx++;
         px = sensor_sel_o[0];
      end
   endtask
   initial begin
      repeat (4) @(negedge clk_i);
      nrst_i = 1'b1;
      check({23'h000000, idle_o}, 24'h000001);
      foreach (RST_TAB[i]) begin
         rd(RST_TAB[i][14:8], 1, v);
         check(v, {16'h0000, RST_TAB[i][7:0]});
      end
      for (int a = 0; a < 3; a++) begin
         rd(7'(36 + 3 * a), 3, v);
         check(v, 24'h000000);
         seed = lfsr(seed);
         wr16(7'(4 + 2 * a), seed[31:16]);
         rd(7'(4 + 2 * a), 2, v);
         check(v, {8'h00, seed[31:16]});
         cc[a] = {13'h0000, seed[2:0]} + 16'h0002;
         wr16(7'(4 + 2 * a), cc[a]);
      end
      for (int m = 1; m < 8; m++) begin
         seed = lfsr(seed);
         fwd_per = seed[3:0] | 4'h2;
         rev_per = seed[7:4] | 4'h2;
         wr8(7'h00, {1'b0, 3'(m), 4'h0});
         wait_on(1'b1, 1'b1);
         wait_on(1'b0, 1'b1);
         for (int a = 0; a < 3; a++) begin
            if (m[a])
               res_exp[a] = exp_res(cc[a], fwd_per, rev_per);
            rd(7'(36 + 3 * a), 3, v);
            check(v, res_exp[a]);
         end
         rd(7'h34, 1, v);
         check(v & 24'h000080, 24'h000080);
         @(negedge clk_i);
         check({23'h000000, idle_o}, 24'h000001);
      end
      for (int a = 0; a < 3; a++) begin
         rd(7'(4 + 2 * a), 2, v);
         check(v, {8'h00, cc[a]});
      end
      wr8(7'h24, 8'hA5);
      rd(7'h24, 3, v);
      check(v, res_exp[0]);
      wr8(7'h0B, 8'h31);
      rd(7'h0B, 1, v);
      check(v, 24'h000091);
      for (int k = 0; k < 3; k++) begin
         en = (k == 2) ? 3'h5 : 3'h7;
         mask = {1'b0, en, 1'b0, k == 1, 1'b0, 1'b1};
         wr8(7'h01, mask);
         wr8(7'h00, 8'h10);
         rd(7'h00, 1, v);
         check(v, 24'h000070);
         watch(4000);
         check({21'h000000, seen_sel}, {21'h000000, en});
         check({23'h000000, seen_late}, {23'h000000, k == 1});
         check({23'h000000, nx > 1}, 24'h000001);
         if (k == 0) begin
            rd(7'h01, 1, v);
            check(v, {16'h0000, mask});
         end else if (k == 1) begin
            wr8(7'h0B, 8'h96);
         end else begin
            wr8(7'h01, mask & 8'hFE);
         end
         // skip the one-cycle gap of a sequence launched at the stop edge
         repeat (2) @(negedge clk_i);
         wait_on(1'b1, 1'b0);
         watch(1200);
         check(nx, 24'h000000);
      end
      complete_run();
   end
endmodule
